//--- verilog/power_clock_pkg.sv
package power_clock_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] clock_gen_mode_reg_addr = 8'h20;
  localparam logic [7:0] power_status_reg_addr   = 8'h30;
  localparam logic [7:0] idle_ctrl_reg_addr      = 8'h00;
  localparam logic [7:0] core_status_reg_addr    = 8'h08;

  // mode register fields
  localparam int osc_enable_bit     = 0;
  localparam int osc_bypass_bit     = 1;
  localparam int out_disable_bit    = 2;
  localparam int css_lo             = 4;
  localparam int pres_lo            = 8;
  localparam int osc_count_lo       = 16;
  localparam int mul_lo             = 24;
  localparam int pll_count_lo       = 12;
  localparam int pll_count_w        = 4;
  // status fields
  localparam int st_osc_stable_bit  = 0;
  localparam int st_lock_bit        = 1;
  localparam int st_slow_event_bit  = 2;
  localparam int st_css_lo          = 4;

  localparam logic [31:0] mode_reset = 32'h0000_0000;

  // ****************************************
  // timing
  // ****************************************
  localparam int backup_stretch_cycles = 32768;
  localparam int osc_div_cycles        = 8;
  localparam real sys_clk_mhz          = 200.0;
  localparam real slow_clk_hz          = 32768.0;
  localparam int slow_div_default      = int'(sys_clk_mhz * 1.0e6 / slow_clk_hz);

  typedef enum logic [1:0] {src_slow, src_main, src_pll, src_rsvd} clk_src_t;
  typedef enum {sw_idle, sw_stop_old, sw_start_new} sw_state_t;

  typedef struct packed {
    logic [5:0] multiplier;
    logic [7:0] osc_count;
    logic [3:0] pll_count;
    logic [2:0] prescale;
    clk_src_t   source;
    logic       out_disable;
    logic       bypass;
    logic       osc_enable;
  } mode_t;

  function automatic mode_t decode_mode(input logic [31:0] w);
    mode_t m;
    m.multiplier  = w[mul_lo +: 6];
    m.osc_count   = w[osc_count_lo +: 8];
    m.pll_count   = w[pll_count_lo +: pll_count_w];
    m.prescale    = w[pres_lo +: 3];
    m.source      = clk_src_t'(w[css_lo +: 2]);
    m.out_disable = w[out_disable_bit];
    m.bypass      = w[osc_bypass_bit];
    m.osc_enable  = w[osc_enable_bit];
    return m;
  endfunction

  function automatic logic [31:0] encode_mode(input mode_t m);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[mul_lo +: 6]                 = m.multiplier;
    w[osc_count_lo +: 8]           = m.osc_count;
    w[pll_count_lo +: pll_count_w] = m.pll_count;
    w[pres_lo +: 3]                = m.prescale;
    w[css_lo +: 2]                 = m.source;
    w[out_disable_bit]             = m.out_disable;
    w[osc_bypass_bit]              = m.bypass;
    w[osc_enable_bit]              = m.osc_enable;
    return w;
  endfunction
endpackage

//--- verilog/power_clock_generator.sv
// Chosen here: the Wishbone interface to the registers and the address map.
`timescale 1ns/10ps
// Operation
// R1 - backup reset held 32768 slow cycles
// R2 - reset leaves slow clock mode
// R3 - slow mode keeps oscillator, pll off (here both run in slow mode if enabled in the mode register)
// R4 - oscillator and pll start disabled
// R5 - oscillator disable clears stable flag
// R6 - oscillator count decrements every 8 cycles
// R7 - bypass takes crystal input pin directly
// R8 - pll ratio is multiplier plus one
// R9 - zero multiplier disables the pll
// R10 - multiplier write clears lock, loads counter
// R11 - software programs lock count at least one
// R12 - pll counter zero sets lock flag
// R13 - software avoids rewrites before lock
// R14 - multiplier change restarts lock sequence
// R15 - pll bypassed while unlocked
// R16 - lock waits for oscillator and pll
// R17 - source select: slow, main, pll
// R18 - unsafe oscillator or slow deselect ignored
// R19 - unsafe pll disable or same-write disable ignored
// R20 - slow switch completion raises event flag
// R21 - software waits for slow event first
// R22 - idle stops core clock until interrupt
// R23 - master clock driven to output pin
// R24 - prescaler divides by 1 to 64
// R25 - output disable tri-states the pin
// R26 - source change glitch-free
module power_clock_generator
  import power_clock_pkg::*;
#(
  parameter int backup_stretch = backup_stretch_cycles,
  parameter int slow_div       = slow_div_default
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        backup_reset_n,
  input  wire logic        crystal_in,
  input  wire logic        irq_pending,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             backup_reset_int_n,
  output logic             main_osc_on,
  output logic             pll_on,
  output logic [6:0]       pll_ratio,
  output logic             master_clock_en,
  output logic             core_clock_en,
  output logic             master_clock_out,
  output logic             master_clock_out_oe_n
);

  // ****************************************
  // slow clock tick and backup reset
  // ****************************************
  logic [31:0] slow_cnt;
  logic        slow_tick;
  logic [31:0] backup_cnt;
  logic        backup_prev;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      slow_cnt  <= 32'h0000_0000;
      slow_tick <= 1'b0;
    end else begin
      slow_tick <= (slow_cnt == 32'(slow_div - 1));
      slow_cnt  <= (slow_cnt == 32'(slow_div - 1)) ? 32'h0000_0000 : slow_cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      backup_cnt         <= 32'h0000_0000;
      backup_reset_int_n <= 1'b0;
      backup_prev        <= 1'b0;
    end else begin
      backup_prev <= backup_reset_n;
      if (!backup_reset_n) begin
        backup_cnt         <= 32'h0000_0000;
        backup_reset_int_n <= 1'b0;
      end else if (!backup_reset_int_n && slow_tick) begin // see R1
        if (backup_cnt == 32'(backup_stretch - 1))
          backup_reset_int_n <= 1'b1;
        backup_cnt <= backup_cnt + 32'h0000_0001;
      end
    end
  end

  // ****************************************
  // mode register and write checks
  // ****************************************
  mode_t       mode;
  mode_t       wr;
  logic        wr_mode;
  logic        wr_ok;
  logic        osc_stable;
  logic        lock;
  logic        slow_event;
  clk_src_t    active_src;
  logic        pll_active;

  assign wr      = decode_mode(wb_dat_i);
  assign wr_mode = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o
                   && wb_adr_i == clock_gen_mode_reg_addr && wb_sel_i == 4'hf;
  assign pll_active = mode.multiplier != 6'h00; // see R9

  always_comb begin
    wr_ok = 1'b1;
    if (wr.source != src_slow && (!mode.osc_enable || !osc_stable)) // see R18
      wr_ok = 1'b0;
    if (!wr.osc_enable && mode.source != src_slow) // see R18
      wr_ok = 1'b0;
    if (wr.multiplier == 6'h00 && mode.source == src_pll) // see R19
      wr_ok = 1'b0;
    if (wr.source == src_pll && wr.multiplier == 6'h00) // see R19
      wr_ok = 1'b0;
    if (wr.source != src_slow && !wr.osc_enable) // see R19
      wr_ok = 1'b0;
    if (wr.source == src_rsvd)
      wr_ok = 1'b0;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      mode <= decode_mode(mode_reset); // see R2 R4
    else if (wr_mode && wr_ok)
      mode <= wr;
  end

  // ****************************************
  // oscillator start-up counter
  // ****************************************
  logic [7:0] osc_cnt;
  logic [2:0] osc_div;
  logic       osc_run;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      osc_cnt    <= 8'h00;
      osc_div    <= 3'h0;
      osc_run    <= 1'b0;
      osc_stable <= 1'b0;
    end else if (wr_mode && wr_ok && wr.osc_enable && !mode.osc_enable) begin
      osc_cnt    <= wr.osc_count; // see R6
      osc_div    <= 3'h0;
      osc_run    <= 1'b1;
      osc_stable <= 1'b0;
    end else if (!mode.osc_enable) begin
      osc_run    <= 1'b0;
      osc_stable <= 1'b0; // see R5
    end else if (osc_run) begin
      osc_div <= osc_div + 3'h1;
      if (osc_div == 3'(osc_div_cycles - 1)) begin // see R6
        if (osc_cnt == 8'h00) begin
          osc_run    <= 1'b0;
          osc_stable <= 1'b1;
        end else
          osc_cnt <= osc_cnt - 8'h01;
      end
    end
  end

  assign main_osc_on = mode.osc_enable && !mode.bypass; // see R3 R7

  // ****************************************
  // pll lock counter
  // ****************************************
  logic [pll_count_w-1:0] pll_cnt;
  logic                   pll_cnt_done;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pll_cnt      <= '0;
      pll_cnt_done <= 1'b0;
    end else if (wr_mode && wr_ok && wr.multiplier != mode.multiplier) begin
      pll_cnt      <= wr.pll_count; // see R10 R14
      pll_cnt_done <= 1'b0;
    end else if (!pll_active)
      pll_cnt_done <= 1'b0;
    else if (slow_tick && !pll_cnt_done) begin
      if (pll_cnt == '0)
        pll_cnt_done <= 1'b1; // see R12
      else
        pll_cnt <= pll_cnt - 1'b1;
    end
  end

  assign lock      = pll_cnt_done && osc_stable; // see R16
  assign pll_on    = pll_active && mode.osc_enable;
  assign pll_ratio = {1'b0, mode.multiplier} + 7'h01; // see R8

  // ****************************************
  // glitch-free source switch
  // ****************************************
  sw_state_t sw_state;
  clk_src_t  target_src;
  clk_src_t  req_src;

  // an unlocked pll falls back to the oscillator path
  assign req_src = (mode.source == src_pll && !lock) ? src_main : mode.source; // see R15

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sw_state   <= sw_idle;
      active_src <= src_slow;
      target_src <= src_slow;
      slow_event <= 1'b0;
    end else begin
      if (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o
          && wb_adr_i == power_status_reg_addr)
        slow_event <= 1'b0;
      case (sw_state)
        sw_idle: begin
          if (req_src != active_src) begin
            target_src <= req_src;
            sw_state   <= sw_stop_old;
          end
        end
        // wait a slow edge so the old clock finishes its pulse
        sw_stop_old: begin
          if (slow_tick)
            sw_state <= sw_start_new; // see R26
        end
        sw_start_new: begin
          if (slow_tick) begin
            sw_state <= sw_idle;
            // a request that moved mid-switch (lock lost) is re-run from idle
            if (target_src == req_src) begin
              active_src <= target_src; // see R15
              if (target_src == src_slow)
                slow_event <= 1'b1; // see R20
            end
          end
        end
        default: sw_state <= sw_idle;
      endcase
    end
  end

  // ****************************************
  // prescaler and outputs
  // ****************************************
  logic       src_edge;
  logic [5:0] pres_cnt;
  logic       osc_edge_prev;
  logic       osc_edge;
  logic       core_run;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      osc_edge_prev <= 1'b0;
    else
      osc_edge_prev <= crystal_in;
  end
  assign osc_edge = crystal_in && !osc_edge_prev; // see R7

  always_comb begin
    case (active_src) // see R17
      src_slow: src_edge = slow_tick;
      src_main: src_edge = osc_edge && osc_stable;
      src_pll:  src_edge = osc_edge && lock;
      default:  src_edge = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pres_cnt        <= 6'h00;
      master_clock_en <= 1'b0;
    end else begin
      master_clock_en <= 1'b0;
      if (src_edge) begin
        if (pres_cnt >= 6'((7'h01 << mode.prescale) - 7'h01)) begin // see R24
          pres_cnt        <= 6'h00;
          master_clock_en <= 1'b1;
        end else
          pres_cnt <= pres_cnt + 6'h01;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      master_clock_out <= 1'b0;
    else if (master_clock_en)
      master_clock_out <= ~master_clock_out; // see R23
  end
  assign master_clock_out_oe_n = mode.out_disable; // see R25

  // idle stop: software write stops core, interrupt wakes it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      core_run <= 1'b1;
    else if (irq_pending)
      core_run <= 1'b1; // see R22
    else if (wr_mode == 1'b0 && wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o
             && wb_adr_i == idle_ctrl_reg_addr && wb_dat_i[0])
      core_run <= 1'b0; // see R22
  end
  assign core_clock_en = core_run && master_clock_en;

  // ****************************************
  // wishbone slave
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      wb_dat_o <= 32'h0000_0000;
      if (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o) begin
        case (wb_adr_i)
          clock_gen_mode_reg_addr: wb_dat_o <= encode_mode(mode);
          power_status_reg_addr: begin
            wb_dat_o[st_osc_stable_bit]  <= osc_stable;
            wb_dat_o[st_lock_bit]        <= lock;
            wb_dat_o[st_slow_event_bit]  <= slow_event;
            wb_dat_o[st_css_lo +: 2]     <= active_src;
          end
          core_status_reg_addr: wb_dat_o[0] <= core_run;
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  bad_source_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R18
    (wr_mode && wr.source != src_slow && !osc_stable) |=> $stable(mode))
    else $error("unsafe source write accepted");
  pll_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R19
    (wr_mode && mode.source == src_pll && wr.multiplier == 6'h00) |=> $stable(mode))
    else $error("pll disabled while selected");
  osc_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R5
    !mode.osc_enable |=> !osc_stable)
    else $error("stable flag survived disable");
  lock_needs_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R16
    lock |-> osc_stable && pll_cnt_done)
    else $error("lock without both counters");
  relock_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R14
    (wr_mode && wr_ok && wr.multiplier != mode.multiplier) |=> !lock)
    else $error("lock kept after multiplier change");
  pll_bypass_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R15
    $rose(active_src == src_pll) |-> $past(lock))
    else $error("unlocked pll selected");
  slow_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R20
    $rose(slow_event) |-> active_src == src_slow)
    else $error("slow event without slow source");
  out_tristate_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R25
    master_clock_out_oe_n == mode.out_disable)
    else $error("output enable wrong");
  backup_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R1
    $rose(backup_reset_int_n) |-> backup_cnt == 32'(backup_stretch))
    else $error("backup reset released early");
  idle_wake_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R22
    irq_pending |=> core_run)
    else $error("core not woken");

endmodule

//--- tb/tb_top.sv
`timescale 1ns/10ps
module tb_top
  import power_clock_pkg::*;
();
  logic        clk_sys;
  logic        rst_n;
  logic        backup_reset_n;
  logic        crystal_in;
  logic        irq_pending;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        backup_reset_int_n;
  logic        main_osc_on;
  logic        pll_on;
  logic [6:0]  pll_ratio;
  logic        master_clock_en;
  logic        core_clock_en;
  logic        master_clock_out;
  logic        master_clock_out_oe_n;
  typedef struct packed {logic [31:0] e; logic [31:0] mk;} note_t;
  note_t       notes[$];
  note_t       nt;
  int          fails;
  int          checks_done;
  int          c;
  int          cc;
  int          mc;
  integer      seed = 32'heb4be52b;
  logic [31:0] cur;
  logic [31:0] q;
  logic [5:0]  m;
  logic        mco;

  // short counts keep the run small
  power_clock_generator #(.backup_stretch(4), .slow_div(4)) uut (.*);

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) crystal_in <= ~crystal_in;

  // ****************************************
  // checking
  // ****************************************
  task results;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // read data is judged against the oldest note; zero mask marks a poll
  always @(posedge clk_sys) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && notes.size() > 0) begin
      nt = notes.pop_front();
      if (nt.mk != 0) chk(wb_dat_o & nt.mk, nt.e);
    end
  end

  initial begin
    repeat (100000) @(posedge clk_sys);
    fails++;
    results();
  end

  // ****************************************
  // bus tasks
  // ****************************************
  task bus(input logic we, input logic [7:0] a, input logic [31:0] d,
           input logic [31:0] e, input logic [31:0] mk);
    int n;
    if (!we) notes.push_back('{e, mk});
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      fails++;
      results();
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 32'h0, 32'h0);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] mk);
    bus(1'b0, a, 32'h0, e, mk);
  endtask

  task poll(input int b, input logic v);
    int n;
    n = 0;
    do begin
      rd(power_status_reg_addr, 32'h0, 32'h0);
      n++;
    end while (q[b] !== v && n < 200);
    if (q[b] !== v) begin
      fails++;
      results();
    end
  endtask

  // cycles between two master clock pulses
  task gap(output int cy);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (master_clock_en !== 1'b1 && n < 1000);
    cy = 0;
    mco = master_clock_out;
    do begin
      @(posedge clk_sys);
      cy++;
    end while (master_clock_en !== 1'b1 && cy < 1000);
    if (master_clock_en !== 1'b1) begin
      fails++;
      results();
    end
  endtask

  // lock count 1 (the minimum), startup count 4
  function automatic logic [31:0] mw(input logic [5:0] mu, input logic [1:0] src,
                                     input logic osc);
    return (32'(mu) << mul_lo) | (32'h1 << pll_count_lo) | (32'h4 << osc_count_lo)
         | (32'(src) << css_lo) | 32'(osc);
  endfunction

  // ****************************************
  // stimulus
  // ****************************************
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    crystal_in = 1'b0;
    irq_pending = 1'b0;
    rst_n = 1'b0;
    backup_reset_n = 1'b0;
    fails = 0;
    checks_done = 0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    backup_reset_n <= 1'b1;
    repeat (12) @(posedge clk_sys);
    chk(backup_reset_int_n, 32'h0);
    repeat (16) @(posedge clk_sys);
    chk(backup_reset_int_n, 32'h1);
    chk({main_osc_on, pll_on, master_clock_out_oe_n}, 32'h0);
    rd(clock_gen_mode_reg_addr, mode_reset, 32'hffffffff);
    rd(power_status_reg_addr, 32'h0, 32'h33);
    for (int p = 0; p < 7; p++) begin
      wr(clock_gen_mode_reg_addr, 32'(p) << pres_lo);
      gap(c);
      gap(c);
      chk(32'(c), 32'(4 << p));
      chk(master_clock_out, !mco);
    end
    cur = 32'h0;
    wr(clock_gen_mode_reg_addr, cur);
    wr(clock_gen_mode_reg_addr, mw(6'h00, 2'h1, 1'b0));
    rd(clock_gen_mode_reg_addr, cur, 32'hffffffff);
    // oscillator and pll started by one write: lock must wait for both
    m = 6'($random(seed));
    if (m == 6'h00) m = 6'h01;
    cur = mw(m, 2'h0, 1'b1);
    wr(clock_gen_mode_reg_addr, cur);
    chk({main_osc_on, pll_on}, 32'h3);
    chk(pll_ratio, m + 1);
    rd(power_status_reg_addr, 32'h0, 32'h3);
    poll(st_lock_bit, 1'b1);
    rd(power_status_reg_addr, 32'h3, 32'h3);
    cur = mw(m, 2'h1, 1'b1);
    wr(clock_gen_mode_reg_addr, cur);
    poll(st_css_lo, 1'b1);
    rd(power_status_reg_addr, 32'h10, 32'h30);
    wr(clock_gen_mode_reg_addr, mw(m, 2'h1, 1'b0));
    rd(clock_gen_mode_reg_addr, cur, 32'hffffffff);
    wr(clock_gen_mode_reg_addr, mw(6'h00, 2'h2, 1'b1));
    rd(clock_gen_mode_reg_addr, cur, 32'hffffffff);
    cur = mw(m, 2'h2, 1'b1);
    wr(clock_gen_mode_reg_addr, cur);
    poll(st_css_lo + 1, 1'b1);
    rd(power_status_reg_addr, 32'h20, 32'h30);
    wr(clock_gen_mode_reg_addr, mw(6'h00, 2'h2, 1'b1));
    rd(clock_gen_mode_reg_addr, cur, 32'hffffffff);
    chk(pll_on, 32'h1);
    // new ratio while running restarts the lock wait
    m = (m == 6'h3f) ? 6'h02 : m + 6'h01;
    cur = mw(m, 2'h2, 1'b1);
    wr(clock_gen_mode_reg_addr, cur);
    rd(power_status_reg_addr, 32'h0, 32'h2);
    chk(pll_ratio, m + 1);
    poll(st_lock_bit, 1'b1);
    cur = mw(m, 2'h0, 1'b1);
    wr(clock_gen_mode_reg_addr, cur);
    poll(st_slow_event_bit, 1'b1);
    rd(power_status_reg_addr, 32'h0, 32'h34);
    cur = mw(6'h00, 2'h0, 1'b1);
    wr(clock_gen_mode_reg_addr, cur);
    chk(pll_on, 32'h0);
    cur = mw(6'h00, 2'h0, 1'b0);
    wr(clock_gen_mode_reg_addr, cur);
    chk(main_osc_on, 32'h0);
    rd(power_status_reg_addr, 32'h0, 32'h1);
    wr(clock_gen_mode_reg_addr, 32'h3);
    chk(main_osc_on, 32'h0);
    wr(clock_gen_mode_reg_addr, 32'h4);
    chk(master_clock_out_oe_n, 32'h1);
    wr(8'h44, $random(seed));
    rd(8'h44, 32'h0, 32'hffffffff);
    // core stops, the master clock keeps running
    wr(idle_ctrl_reg_addr, 32'h1);
    rd(core_status_reg_addr, 32'h0, 32'h1);
    cc = 0;
    mc = 0;
    repeat (40) begin
      @(posedge clk_sys);
      cc += int'(core_clock_en);
      mc += int'(master_clock_en);
    end
    chk(32'(cc), 32'h0);
    chk(32'(mc != 0), 32'h1);
    irq_pending <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rd(core_status_reg_addr, 32'h1, 32'h1);
    irq_pending <= 1'b0;
    repeat (4) @(posedge clk_sys);
    results();
  end
endmodule
